// *** dv/i2cam_master_model.sv ***
// i2c bus master model for the address matcher bench
`timescale 1ns/1ps
`default_nettype none
module i2cam_master_model (
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_m,
   output logic      sda_m,
   output logic      tmo
);
   // ==========================================
   // bus cycles, 125 ns per bit, lines released read high
   initial begin
      scl_m = 1'h1;
      sda_m = 1'h1;
      tmo   = 1'h0;
   end
   task automatic bt(input logic v, output logic r);
      int n;
      sda_m = v;
      #31.25 scl_m = 1'h1;
      n = 0;
      // the slave may stretch; bounded so a stuck clock ends the run
      while (scl_in !== 1'h1 && n < 4000) begin
         #5 n++;
      end
      if (n == 4000) tmo = 1'h1;
      #62.5 r = sda_in;
      scl_m = 1'h0;
      #31.25;
   endtask : bt
   task automatic start;
      sda_m = 1'h1;
      #31.25 scl_m = 1'h1;
      #31.25 sda_m = 1'h0;
      #31.25 scl_m = 1'h0;
      #31.25;
   endtask : start
   task automatic stop;
      sda_m = 1'h0;
      #31.25 scl_m = 1'h1;
      #31.25 sda_m = 1'h1;
      #62.5;
   endtask : stop
   task automatic put(input logic [7:0] b, output logic [7:0] a);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bt(b[i], r);
      end
      bt(1'h1, r);
      a = {7'h00, r};
   endtask : put
endmodule : i2cam_master_model
`default_nettype wire

// *** dv/i2cam_properties.sv ***
// port assertions for the address matcher
`timescale 1ns/1ps
`default_nettype none
module i2cam_properties (
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       scl_oe_n,
   input wire logic       sda_oe_n,
   input wire logic [7:0] address_mask_reg,
   input wire logic       mask_wr,
   input wire logic [7:0] mask_wdata,
   input wire logic       general_call_enable,
   input wire logic       address_hold_enable,
   input wire logic       ack_value_bit,
   input wire logic       release_clock,
   input wire logic       update_address_flag,
   input wire logic       general_call_seen,
   input wire logic       byte_event,
   input wire logic       clock_held
);
   // ==========================================
   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_mr; !$past(rstn) |-> address_mask_reg == 8'hFF; endproperty
   a_mr: assert property (p_mr) else $error("mask reset");
   property p_mw; mask_wr |=> address_mask_reg == $past(mask_wdata); endproperty
   a_mw: assert property (p_mw) else $error("mask load");
   property p_ev; byte_event |=> !byte_event; endproperty
   a_ev: assert property (p_ev) else $error("event width");
   property p_hs; $rose(clock_held) |-> byte_event && address_hold_enable; endproperty
   a_hs: assert property (p_hs) else $error("hold start");
   property p_hk;
      clock_held && !$past(release_clock) |-> !scl_oe_n && sda_oe_n;
   endproperty
   a_hk: assert property (p_hk) else $error("hold level");
   property p_hr;
      clock_held && release_clock |=> (sda_oe_n == $past(ack_value_bit)) ##1 scl_oe_n;
   endproperty
   a_hr: assert property (p_hr) else $error("hold release");
   property p_gc; $rose(general_call_seen) |-> general_call_enable; endproperty
   a_gc: assert property (p_gc) else $error("gcall off");
   property p_ua; $rose(general_call_seen) |-> !$rose(update_address_flag); endproperty
   a_ua: assert property (p_ua) else $error("gcall flag");
endmodule : i2cam_properties
bind i2cam_top i2cam_properties chk_u (.*);
`default_nettype wire

// *** dv/i2cam_top_tb_top.sv ***
// self-checking bench for the address matcher
`timescale 1ns/1ps
`default_nettype none
module i2cam_top_tb_top;
   import i2cam_pkg::*;
   logic       ref_clk, rstn, scl_m, sda_m, tmo, scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic       mask_wr, general_call_enable, address_hold_enable, ten_bit_mode;
   logic       ack_value_bit, ua_clear, update_address_flag;
   logic       release_clock = 1'h0;
   logic       general_call_seen, read_write_bit, byte_event, clock_held;
   logic [9:0] slave_address_reg;
   logic [7:0] mask_wdata, address_mask_reg, receive_buffer_reg, a;
   logic [7:0] nev = 8'h00, nrel = 8'h00, nhd = 8'h00;
   logic [4:0] hc = 5'h00;
   int         failures, n_tests;
   wire logic  scl_in = scl_m & (scl_oe_n | scl_out);
   wire logic  sda_in = sda_m & (sda_oe_n | sda_out);
   i2cam_top dut_u (.*);
   i2cam_master_model m_u (.*);
   // ==========================================
   // clock, software stand-in, helpers
   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // release a stretch after 20 held cycles so the hold is visible
   always @(posedge ref_clk) begin
      hc <= clock_held ? hc + 5'h01 : 5'h00;
      release_clock <= (hc == 5'h14);
      nev <= nev + {7'h00, byte_event === 1'h1};
      nrel <= nrel + {7'h00, release_clock};
      nhd <= nhd + {7'h00, clock_held === 1'h1};
   end
   always @(posedge tmo) begin
      failures++;
      finish_test();
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic cf(input logic [13:0] c);
      @(posedge ref_clk);
      {general_call_enable, address_hold_enable, ten_bit_mode, ack_value_bit,
         slave_address_reg} <= c;
   endtask : cf
   task automatic wm(input logic [7:0] m);
      @(posedge ref_clk);
      {mask_wr, mask_wdata} <= {1'h1, m};
      @(posedge ref_clk);
      mask_wr <= 1'h0;
   endtask : wm
   task automatic x(input logic [7:0] b);
      #1;
      m_u.start();
      m_u.put(b, a);
   endtask : x
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // ==========================================
   // scenarios
   task automatic t_gc;
      logic [7:0] e0;
      e0 = nev;
      cf({4'h8, 10'h0A4});
      x(8'h00);
      chk(a, 8'h00);
      chk(nev - e0, 8'h01);
      chk({7'h00, general_call_seen}, 8'h01);
      m_u.put(8'h3C, a);
      chk(receive_buffer_reg, 8'h3C);
      m_u.stop();
      cf({4'h0, 10'h0A4});
      x(8'h00);
      chk(a, 8'h01);
      m_u.stop();
      wm(8'h00);
      x(8'h00);
      chk(a, 8'h00);
      chk({7'h00, general_call_seen}, 8'h00);
      m_u.stop();
   endtask : t_gc
   task automatic t_mask;
      wm(8'hF1);
      x(8'hAA);
      chk(a, 8'h00);
      m_u.stop();
      x(8'hB4);
      chk(a, 8'h01);
      m_u.stop();
      x(8'hA5);
      chk(a, 8'h00);
      chk({7'h00, read_write_bit}, 8'h01);
      m_u.stop();
      cf({4'h2, 10'h2C5});
      wm(8'h00);
      x(8'hF0);
      chk(a, 8'h01);
      m_u.stop();
      wm(8'hFE);
      x(8'hF4);
      chk({7'h00, update_address_flag}, 8'h01);
      m_u.put(8'hC4, a);
      chk(a, 8'h00);
      m_u.stop();
   endtask : t_mask
   task automatic t_ten_gc;
      cf({4'hA, 10'h2C5});
      ua_clear <= 1'h1;
      @(posedge ref_clk);
      ua_clear <= 1'h0;
      x(8'h00);
      chk({7'h00, update_address_flag}, 8'h00);
      m_u.put(8'h99, a);
      chk(receive_buffer_reg, 8'h99);
      m_u.stop();
   endtask : t_ten_gc
   task automatic t_hold;
      logic [7:0] r0;
      logic [7:0] h0;
      r0 = nrel;
      h0 = nhd;
      cf({4'hC, 10'h0A4});
      x(8'h00);
      chk(a, 8'h00);
      chk(nrel - r0, 8'h01);
      chk(nhd - h0, 8'h17);
      m_u.stop();
      cf({4'hD, 10'h0A4});
      x(8'h00);
      chk(a, 8'h01);
      m_u.stop();
   endtask : t_hold
   task automatic t_rst;
      wm(8'h3C);
      @(posedge ref_clk);
      rstn <= 1'h0;
      #1 chk(address_mask_reg, 8'h3C);
      repeat (4) @(posedge ref_clk);
      rstn <= 1'h1;
      @(posedge ref_clk);
      #1 chk(address_mask_reg, 8'hFF);
   endtask : t_rst
   initial begin
      {rstn, mask_wr, mask_wdata, ua_clear} = '0;
      {general_call_enable, address_hold_enable, ten_bit_mode, ack_value_bit} = '0;
      slave_address_reg = 10'h000;
      failures = 0;
      n_tests = 0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'h1;
      @(posedge ref_clk);
      #1 chk(address_mask_reg, 8'hFF);
      chk({3'h0, scl_out, sda_out, update_address_flag, scl_oe_n, sda_oe_n}, 8'h03);
      t_gc();
      t_mask();
      t_ten_gc();
      t_hold();
      t_rst();
      finish_test();
   end
endmodule : i2cam_top_tb_top
`default_nettype wire

// *** pkg/i2cam_pkg.sv ***
// constants, state enumeration and state record for the i2c slave address matcher
package i2cam_pkg;

   // ==========================================================================
   // address and field constants
   localparam logic [7:0] I2CAM_GCALL_ADDR     = 8'h00;
   localparam logic [7:0] I2CAM_MASK_RESET     = 8'hFF;
   localparam logic [7:0] I2CAM_RW_DONT_CARE   = 8'hFE;
   localparam logic [4:0] I2CAM_TEN_BIT_PREFIX = 5'h1E;
   localparam logic [3:0] I2CAM_BYTE_BITS      = 4'h8;
   localparam logic [3:0] I2CAM_BIT_ONE        = 4'h1;
   localparam logic [3:0] I2CAM_BIT_ZERO       = 4'h0;
   localparam logic [7:0] I2CAM_BYTE_ZERO      = 8'h00;

   // ==========================================================================
   // state types
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HIGH,
      ST_LOW,
      ST_DATA,
      ST_HOLD,
      ST_ACK,
      ST_SKIP
   } i2cam_state_type;

   typedef struct packed {
      i2cam_state_type st;
      i2cam_state_type after_ack;
      logic            scl_s1;
      logic            scl_s2;
      logic            scl_d;
      logic            sda_s1;
      logic            sda_s2;
      logic            sda_d;
      logic [3:0]      bitcnt;
      logic [7:0]      shift;
      logic [7:0]      rx_buf;
      logic [7:0]      mask;
      logic            rw;
      logic            ua;
      logic            gcall;
      logic            event_p;
      logic            scl_oe_n;
      logic            sda_oe_n;
      logic            pin_low;
      logic            held;
   } i2cam_regs_type;

   localparam i2cam_regs_type I2CAM_RESET = '{
      st:        ST_IDLE,
      after_ack: ST_IDLE,
      scl_s1:    1'b1,
      scl_s2:    1'b1,
      scl_d:     1'b1,
      sda_s1:    1'b1,
      sda_s2:    1'b1,
      sda_d:     1'b1,
      bitcnt:    4'h0,
      shift:     8'h00,
      rx_buf:    8'h00,
      mask:      I2CAM_MASK_RESET,
      rw:        1'b0,
      ua:        1'b0,
      gcall:     1'b0,
      event_p:   1'b0,
      scl_oe_n:  1'b1,
      sda_oe_n:  1'b1,
      pin_low:   1'b0,
      held:      1'b0
   };

endpackage : i2cam_pkg

// *** rtl/i2cam_cmp.sv ***
// masked byte comparator for address recognition
`timescale 1ns/1ps
`default_nettype none

module i2cam_cmp (
   input  wire logic [7:0] rx_byte,
   input  wire logic [7:0] ref_byte,
   input  wire logic [7:0] care_mask,
   output logic            match
);

   // ==========================================================================
   // per-bit compare, a zero mask bit makes the bit a don't-care
   logic [7:0] bit_ok;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         assign bit_ok[i] = ~care_mask[i] | ~(rx_byte[i] ^ ref_byte[i]);
      end
   endgenerate

   assign match = &bit_ok;

endmodule : i2cam_cmp

`default_nettype wire

// *** rtl/i2cam_top.sv ***
// i2c slave address recognition with general call, masking and clock hold
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - general call enabled: auto-ack address zero when hold disabled, else ack_value_bit
// - general call enabled: all-zero write address raises byte event
// - ten-bit general call leaves update flag clear
// - after general call next byte is data
// - hold enabled: stretch scl after eighth fall of a recognised address byte
// - keep scl low until software releases
// - mask applied to shifted byte on compare
// - zero mask bit makes bit don't-care
// - mask resets to all ones
// - seven-bit mode masks address bits 7:1
// - ten-bit mode masks low byte 7:0
// - ten-bit high byte compared unmasked
module i2cam_top
   import i2cam_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic [9:0] slave_address_reg,
   input  wire logic       mask_wr,
   input  wire logic [7:0] mask_wdata,
   input  wire logic       general_call_enable,
   input  wire logic       address_hold_enable,
   input  wire logic       ten_bit_mode,
   input  wire logic       ack_value_bit,
   input  wire logic       release_clock,
   input  wire logic       ua_clear,
   output logic [7:0]      address_mask_reg,
   output logic [7:0]      receive_buffer_reg,
   output logic            update_address_flag,
   output logic            general_call_seen,
   output logic            read_write_bit,
   output logic            byte_event,
   output logic            clock_held
);

   // ==========================================================================
   // state
   i2cam_regs_type r_reg;
   i2cam_regs_type r_next;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   logic       addr_match;
   logic       gcall_hit;
   logic [7:0] cmp_ref;
   logic [7:0] cmp_mask;

   // only the second synchroniser stage and its delayed copy feed edge logic
   assign scl_rise   = r_reg.scl_s2 & ~r_reg.scl_d;
   assign scl_fall   = ~r_reg.scl_s2 & r_reg.scl_d;
   assign start_cond = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
   assign stop_cond  = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;

   // ==========================================================================
   // compare operands
   always_comb begin
      // ten-bit low byte: every bit may be masked
      if (r_reg.st == ST_LOW) begin
         cmp_ref  = slave_address_reg[7:0];
         cmp_mask = r_reg.mask;
      end else if (ten_bit_mode) begin
         // ten-bit high byte: fixed prefix, the mask is ignored
         cmp_ref  = {I2CAM_TEN_BIT_PREFIX, slave_address_reg[9:8], 1'b0};
         cmp_mask = I2CAM_RW_DONT_CARE;
      end else begin
         cmp_ref  = {slave_address_reg[7:1], 1'b0};
         cmp_mask = r_reg.mask & I2CAM_RW_DONT_CARE;
      end
   end

   i2cam_cmp u_cmp (
      .rx_byte   (r_reg.shift),
      .ref_byte  (cmp_ref),
      .care_mask (cmp_mask),
      .match     (addr_match)
   );

   // the special path only exists while enabled; otherwise zero takes the masked compare
   assign gcall_hit = general_call_enable && (r_reg.shift == I2CAM_GCALL_ADDR)
                      && (r_reg.st == ST_HIGH);

   // ==========================================================================
   // next state
   always_comb begin
      r_next         = r_reg;
      r_next.scl_s1  = scl_in;
      r_next.scl_s2  = r_reg.scl_s1;
      r_next.scl_d   = r_reg.scl_s2;
      r_next.sda_s1  = sda_in;
      r_next.sda_s2  = r_reg.sda_s1;
      r_next.sda_d   = r_reg.sda_s2;
      r_next.event_p = 1'b0;
      r_next.pin_low = 1'b0;
      if (mask_wr) begin
         r_next.mask = mask_wdata;
      end
      // clear first so a set in the same cycle wins
      if (ua_clear) begin
         r_next.ua = 1'b0;
      end
      // a start restarts recognition from any state, even mid-byte
      if (start_cond) begin
         r_next.st       = ST_HIGH;
         r_next.bitcnt   = I2CAM_BIT_ZERO;
         r_next.gcall    = 1'b0;
         r_next.scl_oe_n = 1'b1;
         r_next.sda_oe_n = 1'b1;
      end else if (stop_cond) begin
         r_next.st       = ST_IDLE;
         r_next.scl_oe_n = 1'b1;
         r_next.sda_oe_n = 1'b1;
      end else begin
         case (r_reg.st)
            ST_HIGH, ST_LOW, ST_DATA: begin
               if (scl_rise) begin
                  r_next.shift  = {r_reg.shift[6:0], r_reg.sda_s2};
                  r_next.bitcnt = 4'(r_reg.bitcnt + I2CAM_BIT_ONE);
               end else if (scl_fall && (r_reg.bitcnt == I2CAM_BYTE_BITS)) begin
                  r_next.bitcnt = I2CAM_BIT_ZERO;
                  r_next.st     = ST_SKIP;
                  if (r_reg.st == ST_DATA) begin
                     r_next.rx_buf    = r_reg.shift;
                     r_next.event_p   = 1'b1;
                     r_next.after_ack = ST_DATA;
                     r_next.st        = ST_ACK;
                     r_next.sda_oe_n  = 1'b0;
                  end else if (gcall_hit || addr_match) begin
                     r_next.rx_buf  = r_reg.shift;
                     r_next.event_p = 1'b1;
                     if (gcall_hit) begin
                        r_next.gcall     = 1'b1;
                        r_next.rw        = 1'b0;
                        r_next.after_ack = ST_DATA;
                     end else if (r_reg.st == ST_LOW) begin
                        r_next.ua        = 1'b1;
                        r_next.after_ack = ST_DATA;
                     end else begin
                        r_next.rw = r_reg.shift[0];
                        if (ten_bit_mode) begin
                           r_next.ua        = 1'b1;
                           r_next.after_ack = r_reg.shift[0] ? ST_SKIP : ST_LOW;
                        end else begin
                           r_next.after_ack = r_reg.shift[0] ? ST_SKIP : ST_DATA;
                        end
                     end
                     if (address_hold_enable) begin
                        r_next.st       = ST_HOLD;
                        r_next.scl_oe_n = 1'b0;
                     end else begin
                        r_next.st       = ST_ACK;
                        r_next.sda_oe_n = 1'b0;
                     end
                  end
               end
            end
            ST_HOLD: begin
               // sda is set one cycle ahead of the scl release for setup
               if (release_clock) begin
                  r_next.sda_oe_n = ack_value_bit;
                  r_next.st       = ST_ACK;
               end
            end
            // released on the ninth fall; a nack sends the frame to skip
            ST_ACK: begin
               r_next.scl_oe_n = 1'b1;
               if (scl_fall) begin
                  r_next.sda_oe_n = 1'b1;
                  r_next.bitcnt   = I2CAM_BIT_ZERO;
                  r_next.st       = r_reg.sda_oe_n ? ST_SKIP : r_reg.after_ack;
               end
            end
            // unmatched, nacked or read frames wait here for start or stop
            default: begin
               r_next.scl_oe_n = 1'b1;
               r_next.sda_oe_n = 1'b1;
            end
         endcase
      end

      // held flag is its own flop so the port is not an inverter
      r_next.held = ~r_next.scl_oe_n;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         r_reg <= I2CAM_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================================
   // outputs
   assign scl_out             = r_reg.pin_low;
   assign scl_oe_n            = r_reg.scl_oe_n;
   assign sda_out             = r_reg.pin_low;
   assign sda_oe_n            = r_reg.sda_oe_n;
   assign address_mask_reg    = r_reg.mask;
   assign receive_buffer_reg  = r_reg.rx_buf;
   assign update_address_flag = r_reg.ua;
   assign general_call_seen   = r_reg.gcall;
   assign read_write_bit      = r_reg.rw;
   assign byte_event          = r_reg.event_p;
   assign clock_held          = r_reg.held;

endmodule : i2cam_top

`default_nettype wire
